// ===== logic/lsb_decoder.sv
`include "lsb_params.svh"

module lsb_decoder (
  input  wire logic              ref_clk,        // core clock
  input  wire logic              resetn,         // sync reset, active low
  input  wire logic              in_valid,       // instruction byte offered
  input  wire logic [7:0]        in_byte,        // instruction byte
  output logic                   in_ready,       // byte taken when valid
  input  wire logic              flag_zero,      // zero flag
  input  wire logic              flag_carry,     // carry flag
  input  wire logic              flag_sign,      // sign flag
  input  wire logic              flag_overflow,  // overflow flag
  input  wire logic              flag_parity,    // parity flag
  input  wire logic [15:0]       count_register, // repeat count
  output logic                   op_valid,       // decoded op pulse
  output lsb_pkg::lsb_kind_t     op_kind,        // decoded form
  output logic [7:0]             op_opcode,      // opcode byte
  output logic                   op_word,        // word operand
  output logic                   op_to_reg,      // d bit of logic ops
  output logic                   op_mem,         // memory operand
  output logic                   op_repeat,      // repeated string op
  output logic [7:0]             op_modrm,       // modrm byte
  output logic [15:0]            op_imm,         // immediate data
  output logic [15:0]            op_disp,        // displacement
  output logic                   op_taken,       // branch taken
  output logic [20:0]            op_cycles,      // execution clocks
  output logic                   exec_busy,      // execution under way
  output logic                   exec_done,      // last execution clock
  output logic                   op_illegal      // byte not decoded here
);

  lsb_pkg::lsb_state_rec_t r_reg;
  lsb_pkg::lsb_state_rec_t r_next;
  logic [20:0]             calc_cycles;
  logic                    br_taken;
  logic                    take;
  logic                    is_string;
  logic [1:0]              mdisp;

  lsb_branch_eval u_branch (
    .opcode        (r_reg.opcode),
    .flag_zero     (flag_zero),
    .flag_carry    (flag_carry),
    .flag_sign     (flag_sign),
    .flag_overflow (flag_overflow),
    .flag_parity   (flag_parity),
    .taken         (br_taken)
  );

  lsb_clock_calc u_calc (
    .kind   (r_reg.kind),
    .mem    (r_reg.mem),
    .rep    (r_reg.rep),
    .taken  (br_taken),
    .count  (count_register),
    .cycles (calc_cycles)
  );

  assign in_ready  = (r_reg.state != lsb_pkg::LSB_S_ISSUE) &&
                     (r_reg.state != lsb_pkg::LSB_S_EXEC);
  assign take      = in_valid && in_ready;
  assign exec_busy = (r_reg.state == lsb_pkg::LSB_S_EXEC);
  assign exec_done = exec_busy && (r_reg.cnt == `LSB_T_ONE);

  // displacement bytes that follow a memory modrm
  always_comb begin
    mdisp = 2'h0;
    if (in_byte[7:6] == `LSB_MOD_DISP8)
      mdisp = 2'h1;
    else if (in_byte[7:6] == `LSB_MOD_DISP16)
      mdisp = 2'h2;
    else if (in_byte[7:6] == 2'h0 && in_byte[2:0] == `LSB_RM_DIRECT)
      mdisp = 2'h2;
  end

  always_comb begin
    r_next          = r_reg;
    r_next.op_valid = 1'b0;
    r_next.illegal  = 1'b0;
    is_string       = 1'b0;
    unique case (r_reg.state)
      lsb_pkg::LSB_S_OPCODE: begin
        if (take) begin
          r_next.opcode = in_byte;
          r_next.mem    = 1'b0;
          r_next.imm    = 16'h0;
          r_next.disp   = 16'h0;
          r_next.modrm  = 8'h0;
          r_next.kind   = lsb_pkg::LSB_K_NONE;
          if (in_byte == `LSB_REP_PREFIX) begin
            r_next.rep = 1'b1;
          end else if (in_byte[7:2] == `LSB_AND_OP || in_byte[7:2] == `LSB_OR_OP ||
                       in_byte[7:2] == `LSB_XOR_OP) begin
            r_next.kind  = lsb_pkg::LSB_K_LOGIC;
            r_next.state = lsb_pkg::LSB_S_MODRM;
          end else if (in_byte[7:1] == `LSB_TEST_RM_OP) begin
            r_next.kind  = lsb_pkg::LSB_K_TEST_RM;
            r_next.state = lsb_pkg::LSB_S_MODRM;
          end else if (in_byte[7:1] == `LSB_GRP_TEST_OP) begin
            r_next.kind  = lsb_pkg::LSB_K_TEST_IMM;
            r_next.state = lsb_pkg::LSB_S_MODRM;
          end else if (in_byte[7:1] == `LSB_TEST_ACC_OP) begin
            r_next.kind  = lsb_pkg::LSB_K_TEST_ACC;
            r_next.state = lsb_pkg::LSB_S_IMM_LO;
          end else if (in_byte[7:4] == `LSB_BRANCH_NIB) begin
            r_next.kind  = lsb_pkg::LSB_K_BRANCH;
            r_next.state = lsb_pkg::LSB_S_BDISP;
          end else begin
            is_string = 1'b1;
            unique case (in_byte[7:1])
              `LSB_MOVE_OP:    r_next.kind = lsb_pkg::LSB_K_MOVE;
              `LSB_INPUT_OP:   r_next.kind = lsb_pkg::LSB_K_INPUT;
              `LSB_OUTPUT_OP:  r_next.kind = lsb_pkg::LSB_K_OUTPUT;
              `LSB_COMPARE_OP: r_next.kind = lsb_pkg::LSB_K_COMPARE;
              `LSB_SCAN_OP:    r_next.kind = lsb_pkg::LSB_K_SCAN;
              `LSB_LOAD_OP:    r_next.kind = lsb_pkg::LSB_K_LOAD;
              `LSB_STORE_OP:   r_next.kind = lsb_pkg::LSB_K_STORE;
              default:         is_string   = 1'b0;
            endcase
            if (is_string) begin
              r_next.state = lsb_pkg::LSB_S_ISSUE;
            end else begin
              r_next.illegal = 1'b1;
              r_next.rep     = 1'b0;
            end
          end
          // a prefix ahead of a non-string form is dropped
          if (in_byte != `LSB_REP_PREFIX && !is_string)
            r_next.rep = 1'b0;
        end
      end
      lsb_pkg::LSB_S_MODRM: begin
        if (take) begin
          r_next.modrm     = in_byte;
          r_next.mem       = (in_byte[7:6] != `LSB_MOD_REG);
          r_next.disp_left = (in_byte[7:6] == `LSB_MOD_REG) ? 2'h0 : mdisp;
          if (r_reg.kind == lsb_pkg::LSB_K_TEST_IMM &&
              in_byte[5:3] != `LSB_TEST_REG_FIELD) begin
            // other reg fields of this opcode belong to other units
            r_next.illegal = 1'b1;
            r_next.state   = lsb_pkg::LSB_S_OPCODE;
          end else if (in_byte[7:6] != `LSB_MOD_REG && mdisp != 2'h0) begin
            r_next.state = lsb_pkg::LSB_S_MDISP;
          end else if (r_reg.kind == lsb_pkg::LSB_K_TEST_IMM) begin
            r_next.state = lsb_pkg::LSB_S_IMM_LO;
          end else begin
            r_next.state = lsb_pkg::LSB_S_ISSUE;
          end
        end
      end
      lsb_pkg::LSB_S_MDISP: begin
        if (take) begin
          if (r_reg.disp_left == 2'h2)
            r_next.disp[7:0] = in_byte;
          else if (r_reg.modrm[7:6] == `LSB_MOD_DISP8)
            r_next.disp = {{8{in_byte[7]}}, in_byte};
          else
            r_next.disp[15:8] = in_byte;
          r_next.disp_left = r_reg.disp_left - 2'h1;
          if (r_reg.disp_left == 2'h1)
            r_next.state = (r_reg.kind == lsb_pkg::LSB_K_TEST_IMM) ?
                           lsb_pkg::LSB_S_IMM_LO : lsb_pkg::LSB_S_ISSUE;
        end
      end
      lsb_pkg::LSB_S_IMM_LO: begin
        if (take) begin
          r_next.imm = {8'h0, in_byte};
          // second immediate byte only for word forms
          r_next.state = r_reg.opcode[0] ? lsb_pkg::LSB_S_IMM_HI :
                         lsb_pkg::LSB_S_ISSUE;
        end
      end
      lsb_pkg::LSB_S_IMM_HI: begin
        if (take) begin
          r_next.imm[15:8] = in_byte;
          r_next.state     = lsb_pkg::LSB_S_ISSUE;
        end
      end
      lsb_pkg::LSB_S_BDISP: begin
        if (take) begin
          r_next.disp  = {{8{in_byte[7]}}, in_byte};
          r_next.state = lsb_pkg::LSB_S_ISSUE;
        end
      end
      lsb_pkg::LSB_S_ISSUE: begin
        // flags and count sampled here, after the last byte
        r_next.cycles   = calc_cycles;
        r_next.cnt      = calc_cycles;
        r_next.taken    = (r_reg.kind == lsb_pkg::LSB_K_BRANCH) && br_taken;
        r_next.op_valid = 1'b1;
        r_next.state    = lsb_pkg::LSB_S_EXEC;
      end
      lsb_pkg::LSB_S_EXEC: begin
        r_next.cnt = r_reg.cnt - `LSB_T_ONE;
        if (r_reg.cnt == `LSB_T_ONE) begin
          r_next.state = lsb_pkg::LSB_S_OPCODE;
          r_next.rep   = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r_reg <= '{state: lsb_pkg::LSB_S_OPCODE, kind: lsb_pkg::LSB_K_NONE,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign op_valid   = r_reg.op_valid;
  assign op_kind    = r_reg.kind;
  assign op_opcode  = r_reg.opcode;
  // branches carry no w bit
  assign op_word    = (r_reg.kind != lsb_pkg::LSB_K_BRANCH) &&
                      (r_reg.kind != lsb_pkg::LSB_K_NONE) && r_reg.opcode[0];
  assign op_to_reg  = (r_reg.kind == lsb_pkg::LSB_K_LOGIC) && r_reg.opcode[1];
  assign op_mem     = r_reg.mem;
  assign op_repeat  = r_reg.rep;
  assign op_modrm   = r_reg.modrm;
  assign op_imm     = r_reg.imm;
  assign op_disp    = r_reg.disp;
  assign op_taken   = r_reg.taken;
  assign op_cycles  = r_reg.cycles;
  assign op_illegal = r_reg.illegal;

  logic_timing_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_LOGIC |-> op_cycles == (op_mem ? 21'h7 : 21'h1))
    else $error("logic op clock count wrong");

  test_reg_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_TEST_RM && op_mem |-> ##6 exec_done)
    else $error("memory test did not end after 7 clocks");

  test_imm_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_TEST_IMM
    |-> op_cycles == (op_mem ? 21'h8 : 21'h1) && op_modrm[5:3] == 3'h0)
    else $error("immediate test decode wrong");

  acc_test_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_TEST_ACC |-> exec_done ##1 in_ready)
    else $error("accumulator test not one clock");

  move_single_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_MOVE && !op_repeat |-> (!exec_done)[*8] ##5 exec_done)
    else $error("move string not 13 clocks");

  store_rep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_STORE && op_repeat
    |-> op_cycles == 21'h4 + 21'h3 * {5'h0, $past(count_register)})
    else $error("repeated store clock count wrong");

  compare_rep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_COMPARE && op_repeat
    |-> op_cycles == 21'h4 + 21'h12 * {5'h0, $past(count_register)})
    else $error("repeated compare clock count wrong");

  branch_cycles_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_kind == lsb_pkg::LSB_K_BRANCH |-> op_cycles == (op_taken ? 21'h9 : 21'h1))
    else $error("branch clock count wrong");

  branch_ne_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_opcode == `LSB_BR_NE && op_kind == lsb_pkg::LSB_K_BRANCH
    |-> op_taken == !$past(flag_zero))
    else $error("not-equal branch decision wrong");

  branch_lt_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_opcode == `LSB_BR_LT && op_kind == lsb_pkg::LSB_K_BRANCH
    |-> op_taken == ($past(flag_sign) ^ $past(flag_overflow)))
    else $error("signed less branch decision wrong");

  branch_above_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    op_valid && op_opcode == `LSB_BR_ABOVE && op_kind == lsb_pkg::LSB_K_BRANCH
    |-> op_taken == !($past(flag_carry) || $past(flag_zero)))
    else $error("above branch decision wrong");

endmodule

// ===== logic/lsb_params.svh
`ifndef LSB_PARAMS_SVH
`define LSB_PARAMS_SVH

// prefix and opcode patterns, upper bits only where a w or d bit or the branch condition field follows
`define LSB_REP_PREFIX      8'hf2
`define LSB_AND_OP          6'h08
`define LSB_OR_OP           6'h02
`define LSB_XOR_OP          6'h0c
`define LSB_TEST_RM_OP      7'h42
`define LSB_GRP_TEST_OP     7'h7b
`define LSB_TEST_ACC_OP     7'h54
`define LSB_MOVE_OP         7'h52
`define LSB_INPUT_OP        7'h36
`define LSB_OUTPUT_OP       7'h37
`define LSB_COMPARE_OP      7'h53
`define LSB_SCAN_OP         7'h57
`define LSB_LOAD_OP         7'h56
`define LSB_STORE_OP        7'h55
`define LSB_BRANCH_NIB      4'h7

// branch opcodes, full byte
`define LSB_BR_EQ           8'h74
`define LSB_BR_NE           8'h75
`define LSB_BR_LT           8'h7c
`define LSB_BR_LE           8'h7e
`define LSB_BR_CARRY        8'h72
`define LSB_BR_BE           8'h76
`define LSB_BR_PE           8'h7a
`define LSB_BR_NC           8'h73
`define LSB_BR_GE           8'h7d
`define LSB_BR_ABOVE        8'h77

// branch condition field, opcode bits 3:1
`define LSB_CC_OVF          3'h0
`define LSB_CC_CARRY        3'h1
`define LSB_CC_ZERO         3'h2
`define LSB_CC_BELOW_EQ     3'h3
`define LSB_CC_SIGN         3'h4
`define LSB_CC_PARITY       3'h5
`define LSB_CC_LESS         3'h6
`define LSB_CC_LESS_EQ      3'h7

// modrm fields
`define LSB_MOD_REG         2'h3
`define LSB_MOD_DISP8       2'h1
`define LSB_MOD_DISP16      2'h2
`define LSB_RM_DIRECT       3'h6
`define LSB_TEST_REG_FIELD  3'h0

// clock counts
`define LSB_T_ONE           21'h1
`define LSB_T_LOGIC_MEM     21'h7
`define LSB_T_TEST_IMM_MEM  21'h8
`define LSB_T_BR_TAKEN      21'h9
`define LSB_T_MOVE          21'hd
`define LSB_T_IO            21'hd
`define LSB_T_COMPARE       21'h12
`define LSB_T_SCAN          21'hd
`define LSB_T_LOAD          21'hd
`define LSB_T_STORE         21'h7
`define LSB_R_MOVE_BASE     21'h4
`define LSB_R_IO_BASE       21'h5
`define LSB_R_CMP_BASE      21'h4
`define LSB_R_SCAN_BASE     21'h4
`define LSB_R_LOAD_BASE     21'h3
`define LSB_R_STORE_BASE    21'h4
`define LSB_R_MOVE_PER      21'h9
`define LSB_R_IO_PER        21'h9
`define LSB_R_CMP_PER       21'h12
`define LSB_R_SCAN_PER      21'hd
`define LSB_R_LOAD_PER      21'h9
`define LSB_R_STORE_PER     21'h3

`endif

// ===== logic/lsb_pkg.sv
package lsb_pkg;

  typedef enum logic [3:0] {
    LSB_K_NONE, LSB_K_LOGIC, LSB_K_TEST_RM, LSB_K_TEST_IMM, LSB_K_TEST_ACC,
    LSB_K_MOVE, LSB_K_INPUT, LSB_K_OUTPUT, LSB_K_COMPARE, LSB_K_SCAN,
    LSB_K_LOAD, LSB_K_STORE, LSB_K_BRANCH
  } lsb_kind_t;

  typedef enum logic [2:0] {
    LSB_S_OPCODE, LSB_S_MODRM, LSB_S_MDISP, LSB_S_IMM_LO, LSB_S_IMM_HI,
    LSB_S_BDISP, LSB_S_ISSUE, LSB_S_EXEC
  } lsb_state_t;

  typedef struct packed {
    lsb_state_t state;
    lsb_kind_t  kind;
    logic [7:0] opcode;
    logic       rep;
    logic       mem;
    logic [7:0] modrm;
    logic [15:0] imm;
    logic [15:0] disp;
    logic [1:0] disp_left;
    logic [20:0] cnt;
    logic [20:0] cycles;
    logic       op_valid;
    logic       taken;
    logic       illegal;
  } lsb_state_rec_t;

endpackage

// ===== logic/lsb_branch_eval.sv
`include "lsb_params.svh"

module lsb_branch_eval (
  input  wire logic [7:0] opcode,        // branch opcode byte
  input  wire logic       flag_zero,     // zero flag
  input  wire logic       flag_carry,    // carry flag
  input  wire logic       flag_sign,     // sign flag
  input  wire logic       flag_overflow, // overflow flag
  input  wire logic       flag_parity,   // parity flag, high on even
  output logic            taken          // condition holds
);

  logic cond;

  always_comb begin
    unique case (opcode[3:1])
      `LSB_CC_OVF:      cond = flag_overflow;
      `LSB_CC_CARRY:    cond = flag_carry;
      `LSB_CC_ZERO:     cond = flag_zero;
      `LSB_CC_BELOW_EQ: cond = flag_carry | flag_zero;
      `LSB_CC_SIGN:     cond = flag_sign;
      `LSB_CC_PARITY:   cond = flag_parity;
      `LSB_CC_LESS:     cond = flag_sign ^ flag_overflow;
      `LSB_CC_LESS_EQ:  cond = flag_zero | (flag_sign ^ flag_overflow);
    endcase
  end

  // low opcode bit selects the complementary branch
  assign taken = cond ^ opcode[0];
endmodule

// ===== logic/lsb_clock_calc.sv
`include "lsb_params.svh"

module lsb_clock_calc (
  input  wire lsb_pkg::lsb_kind_t kind,      // decoded form
  input  wire logic               mem,       // memory operand
  input  wire logic               rep,       // repeat prefix seen
  input  wire logic               taken,     // branch condition holds
  input  wire logic [15:0]        count,     // count_register value
  output logic [20:0]             cycles     // execution clocks
);

  logic [20:0] single;
  logic [20:0] base;
  logic [20:0] per;
  logic        is_string;

  always_comb begin
    single    = `LSB_T_ONE;
    base      = `LSB_T_ONE;
    per       = `LSB_T_ONE;
    is_string = 1'b1;
    unique case (kind)
      lsb_pkg::LSB_K_MOVE:    begin single = `LSB_T_MOVE; base = `LSB_R_MOVE_BASE;
                                per = `LSB_R_MOVE_PER; end
      lsb_pkg::LSB_K_INPUT,
      lsb_pkg::LSB_K_OUTPUT:  begin single = `LSB_T_IO; base = `LSB_R_IO_BASE;
                                per = `LSB_R_IO_PER; end
      lsb_pkg::LSB_K_COMPARE: begin single = `LSB_T_COMPARE; base = `LSB_R_CMP_BASE;
                                per = `LSB_R_CMP_PER; end
      lsb_pkg::LSB_K_SCAN:    begin single = `LSB_T_SCAN; base = `LSB_R_SCAN_BASE;
                                per = `LSB_R_SCAN_PER; end
      lsb_pkg::LSB_K_LOAD:    begin single = `LSB_T_LOAD; base = `LSB_R_LOAD_BASE;
                                per = `LSB_R_LOAD_PER; end
      lsb_pkg::LSB_K_STORE:   begin single = `LSB_T_STORE; base = `LSB_R_STORE_BASE;
                                per = `LSB_R_STORE_PER; end
      lsb_pkg::LSB_K_LOGIC,
      lsb_pkg::LSB_K_TEST_RM: begin is_string = 1'b0;
                                single = mem ? `LSB_T_LOGIC_MEM : `LSB_T_ONE; end
      lsb_pkg::LSB_K_TEST_IMM: begin is_string = 1'b0;
                                single = mem ? `LSB_T_TEST_IMM_MEM : `LSB_T_ONE; end
      lsb_pkg::LSB_K_BRANCH:  begin is_string = 1'b0;
                                single = taken ? `LSB_T_BR_TAKEN : `LSB_T_ONE; end
      lsb_pkg::LSB_K_TEST_ACC,
      lsb_pkg::LSB_K_NONE:    is_string = 1'b0;
    endcase
    // 21 bits hold the slowest repeat at full count
    if (is_string && rep)
      cycles = base + per * {5'h0, count};
    else
      cycles = single;
  end
endmodule

// ===== tb/lsb_queue_model.sv
module lsb_queue_model (
  input  wire logic       ref_clk,  // core clock
  input  wire logic       in_ready, // decoder takes a byte
  input  wire logic       slow,     // leave a random idle gap before the first byte after an empty queue
  output logic            in_valid, // byte offered
  output logic [7:0]      in_byte   // offered byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] byte_q[$];
  logic       will_take;
  int         seed;

  task automatic push(input logic [7:0] b);
    byte_q.push_back(b);
  endtask

  initial begin
    in_valid  = 1'b0;
    in_byte   = 8'h00;
    will_take = 1'b0;
    seed      = 18;
  end

  // an offer is held until the edge that sees ready, then dropped here
  always @(negedge ref_clk) begin
    if (will_take) begin
      void'(byte_q.pop_front());
    end
    if (byte_q.size() > 0 && (in_valid || !slow || ($random(seed) & 3) == 0)) begin
      in_valid = 1'b1;
      in_byte  = byte_q[0];
    end else begin
      // released bus shows junk, all bits flipped each idle cycle, so the old byte on every second one
      in_valid = 1'b0;
      in_byte  = ~in_byte;
    end
    will_take = in_valid && in_ready;
  end
endmodule

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk, resetn, slow, in_valid, in_ready, op_illegal;
  logic [7:0]         in_byte, op, b, md, op_opcode, op_modrm;
  logic [4:0]         flg;
  logic [15:0]        cnt, op_imm, op_disp;
  logic [20:0]        op_cycles;
  lsb_pkg::lsb_kind_t op_kind;
  logic               op_valid, op_word, op_mem, op_repeat, op_taken, exec_busy, exec_done;
  logic               tk, w, op_to_reg;
  int                 seed, errors, total_checks, i, j, n;
  logic [20:0]        ec[$];
  logic               ew[$], ed[$];
  lsb_pkg::lsb_kind_t ek[$];
  logic [7:0]         lg[4] = '{8'h20, 8'h08, 8'h30, 8'h84};
  logic [7:0]         so[7] = '{8'ha4, 8'h6c, 8'h6e, 8'ha6, 8'hae, 8'hac, 8'haa};
  logic [7:0]         br[10] = '{8'h74, 8'h75, 8'h7c, 8'h7e, 8'h72, 8'h76, 8'h7a, 8'h73,
                                 8'h7d, 8'h77};
  int                 s1[7] = '{13, 13, 13, 18, 13, 13, 7};
  int                 sb[7] = '{4, 5, 5, 4, 4, 3, 4};
  int                 sp[7] = '{9, 9, 9, 18, 13, 9, 3};

  lsb_decoder dut_u (.ref_clk(ref_clk), .resetn(resetn), .in_valid(in_valid), .in_byte(in_byte),
    .in_ready(in_ready), .flag_zero(flg[0]), .flag_carry(flg[1]), .flag_sign(flg[2]),
    .flag_overflow(flg[3]), .flag_parity(flg[4]), .count_register(cnt), .op_valid(op_valid),
    .op_kind(op_kind), .op_opcode(op_opcode), .op_word(op_word), .op_to_reg(op_to_reg),
    .op_mem(op_mem), .op_repeat(op_repeat), .op_modrm(op_modrm), .op_imm(op_imm),
    .op_disp(op_disp), .op_taken(op_taken), .op_cycles(op_cycles), .exec_busy(exec_busy),
    .exec_done(exec_done), .op_illegal(op_illegal));
  lsb_queue_model qm_u (.ref_clk(ref_clk), .in_ready(in_ready), .slow(slow),
    .in_valid(in_valid), .in_byte(in_byte));

  function automatic logic br_exp(input logic [7:0] o, input logic [4:0] f);
    logic z, c, s, v, p;
    {p, v, s, c, z} = f;
    case (o)
      8'h74: return z;
      8'h75: return !z;
      8'h7c: return s ^ v;
      8'h7e: return (s ^ v) | z;
      8'h72: return c;
      8'h76: return c | z;
      8'h7a: return p;
      8'h73: return !c;
      8'h7d: return !(s ^ v);
      default: return !(c | z);
    endcase
  endfunction

  function automatic logic [20:0] str_cyc(input int k, input logic rep, input logic [15:0] c);
    return rep ? 21'(sb[k]) + 21'(sp[k]) * 21'(c) : 21'(s1[k]);
  endfunction

  task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // waits for the decode pulse, then times the busy window up to its done pulse
  task automatic expect_op(input lsb_pkg::lsb_kind_t k, input logic [20:0] cyc, input logic t,
                           input logic wd, input logic rp);
    int m;
    m = 0;
    while (op_valid !== 1'b1 && m < 300) begin
      @(posedge ref_clk);
      #1;
      m++;
    end
    cmp(m < 300, 1'b1);
    cmp(op_kind, k);
    cmp(op_cycles, cyc);
    if (k == lsb_pkg::LSB_K_BRANCH) cmp(op_taken, t);
    else cmp(op_word, wd);
    cmp(op_repeat, rp);
    m = 0;
    while (exec_done !== 1'b1) begin
      m += exec_busy;
      @(posedge ref_clk);
      #1;
    end
    cmp(21'(m + 1), cyc);
    // step past the done cycle so a one-clock op is not seen twice
    @(posedge ref_clk);
    #1;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    #300000;
    errors++;
    stop_test;
  end

  initial begin
    seed = 18;
    errors = 0;
    total_checks = 0;
    resetn = 1'b0;
    slow = 1'b1;
    flg = 5'h00;
    cnt = 16'h0000;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    // queued ahead so each later byte is held off during issue and execution
    for (i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      op = lg[i % 4] | (b & ((i % 4 == 3) ? 8'h01 : 8'h03));
      qm_u.push(op);
      qm_u.push(i < 8 ? (8'hc0 | b) : (i < 12 ? (b & 8'h38) : (8'h40 | (b & 8'h38))));
      if (i >= 12) qm_u.push(b);
      ec.push_back(i < 8 ? 21'h1 : 21'h7);
      ew.push_back(op[0]);
      ed.push_back(op[1]);
      ek.push_back(i % 4 == 3 ? lsb_pkg::LSB_K_TEST_RM : lsb_pkg::LSB_K_LOGIC);
    end
    for (i = 0; i < 16; i++) begin
      expect_op(ek[i], ec[i], 1'b0, ew[i], 1'b0);
      cmp(op_to_reg, ed[i]);
    end
    for (i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      w = i[0];
      slow = i[2];
      qm_u.push((i < 4 ? 8'hf6 : 8'ha8) | {7'h00, w});
      md = (i < 4) ? (i[1] ? (b & 8'h05) : (8'hc0 | (b & 8'h07))) : 8'h00;
      if (i < 4) qm_u.push(md);
      qm_u.push(b);
      if (w) qm_u.push(~b);
      expect_op(i < 4 ? lsb_pkg::LSB_K_TEST_IMM : lsb_pkg::LSB_K_TEST_ACC,
                (i < 4 && i[1]) ? 21'h8 : 21'h1, 1'b0, w, 1'b0);
      cmp(op_imm, w ? {~b, b} : {8'h00, b});
      cmp(op_modrm, md);
    end
    qm_u.push(8'hf7);
    qm_u.push(8'hd0);
    n = 0;
    while (op_illegal !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmp(n < 50, 1'b1);
    for (i = 0; i < 28; i++) begin
      j = i % 7;
      @(negedge ref_clk);
      cnt = (i < 7) ? 16'h0000 : (16'($random(seed)) & 16'h0007);
      tk = !(i >= 7 && i < 14);
      w = cnt[0] ^ i[0];
      slow = i[1];
      if (tk) qm_u.push(8'hf2);
      qm_u.push(so[j] | {7'h00, w});
      expect_op(lsb_pkg::lsb_kind_t'(int'(lsb_pkg::LSB_K_MOVE) + j), str_cyc(j, tk, cnt),
                1'b0, w, tk);
      cmp(op_repeat, 1'b0);
    end
    for (i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      flg = (i < 10) ? 5'h00 : 5'($random(seed));
      op = br[i % 10];
      if (i % 7 == 0) qm_u.push(8'hf2);
      qm_u.push(op);
      b = 8'($random(seed));
      qm_u.push(b);
      tk = br_exp(op, flg);
      expect_op(lsb_pkg::LSB_K_BRANCH, tk ? 21'h9 : 21'h1, tk, 1'b0,
                1'b0);
      cmp(op_repeat, 1'b0);
      cmp(op_disp, {{8{b[7]}}, b});
      cmp(op_opcode, op);
    end
    stop_test;
  end
endmodule
